// ===== dpc_map.svh
// Register map, field positions, reset values and timing counts
// for the playback control block. Included by the top and the bench.
//
// Summary of operation
// R1 - Mono bit sums left and right, halves, feeds both outputs.
// R2 - Frame-rate mode: set gives 272 clocks per sample, clear 256.
// R3 - De-emphasis 00 none; 01, 10, 11 select 32k, 44.1k, 48k.
// R4 - Fast clock bit runs the modulator above 64 times the rate.
// R5 - Invert bits flip channel polarity; left bit 1, right bit 0. Ignored while mono is set.
// R6 - New volumes wait for an update-bit write; both update together.
// R7 - Volume code 0 mutes, 1 is -71.625dB, 0.375dB per code.
// R8 - Volume codes reset to 1100_0000, which is 0dB.
// R9 - Frame clock generated when enabled and in master mode.
// R10 - Bit clocks per frame phase 8 to 2047; lower codes invalid.
// R11 - Divider codes 0..6 divide by 1,1.5,2,3,4,5.5,6; 7 reserved.
// R12 - Mute bit resets to 1; output muted until cleared.
// R13 - Channel enables reset to 0; channel runs only when enabled.
// R14 - On unmute, jump to volume or ramp up, per mute-mode bit.
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DPC_OFS_CTRL      8'h30
`define DPC_OFS_VOL_L     8'h32
`define DPC_OFS_VOL_R     8'h33
`define DPC_OFS_FRAME     8'h35
`define DPC_OFS_CLK       8'h36
`define DPC_OFS_MUTE      8'h3a
`define DPC_OFS_MUTE_MODE 8'h3b
`define DPC_OFS_STATUS    8'h3f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DPC_BIT_MONO      13
`define DPC_BIT_RATE_MODE 12
`define DPC_BIT_DEEMPHASIS_SELECT_HI  5
`define DPC_BIT_DEEMPHASIS_SELECT_LO  4
`define DPC_BIT_FAST_MOD  3
`define DPC_BIT_INV_L     1
`define DPC_BIT_INV_R     0
`define DPC_BIT_CH_EN     15
`define DPC_BIT_VU        8
`define DPC_BIT_FCLK_EN   11
`define DPC_BIT_CLK_POL   4
`define DPC_BIT_MUTE      14
`define DPC_BIT_RAMP_SEL  14

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define DPC_RST_VOL       8'hc0
`define DPC_RST_BCPS      11'h040
`define DPC_RST_MUTE      1'b1
`define DPC_MIN_BCPS      11'h008
`define DPC_VOL_0DB       9'h0c0

// ----------------------------------------------------------------
// Clocks per sample, in normal and USB frame-rate mode; FIFO depth
// ----------------------------------------------------------------
`define DPC_CPS_NORMAL    12'd256
`define DPC_CPS_USB       12'd272
`define DPC_FIFO_DEPTH    4

`endif

// ===== dpc_pkg.sv
// Types shared by the playback control block.
// Uses no macros from dpc_map.svh.
package dpc_pkg;

  typedef logic signed [15:0] dpc_pcm_t;

  // One stereo sample
  typedef struct packed {
    dpc_pcm_t left;
    dpc_pcm_t right;
  } dpc_sample_s;

  // Settings handed to the analogue and filter stages
  typedef struct packed {
    logic       frame_rate_mode_select;
    logic [1:0] deemphasis_select;
    logic       modulator_fast_clock;
    logic       playback_clock_invert;
    logic [2:0] sample_rate_divider;
    logic       left_channel_enable;
    logic       right_channel_enable;
  } dpc_cfg_s;

endpackage : dpc_pkg

// ===== dpc_top.sv
// Playback control: register bank, sample FIFO, volume/mute path,
// sample-rate tick and frame clock generator.
// Assumes one clock, register strobes and bit-clock ticks synchronous.
`timescale 1ns/1ps
`include "dpc_map.svh"

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module dpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,      // Clock
  input  wire logic             rst_n,    // Sync reset, low
  input  wire logic             ce,       // Clock enable
  input  wire logic             s_valid,  // Write side valid
  output logic                  s_ready,  // Write side ready
  input  wire logic [WIDTH-1:0] s_data,   // Write data
  output logic                  m_valid,  // Read side valid
  input  wire logic             m_ready,  // Read side ready
  output logic [WIDTH-1:0]      m_data,   // Read data
  output logic [$clog2(DEPTH):0] level    // Words held
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Honest full and empty
  assign s_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign m_valid = (cnt_q != '0);
  assign push    = s_valid & s_ready;
  assign pop     = m_valid & m_ready;
  assign m_data  = mem_q[rp_q];
  assign level   = cnt_q;

  // Storage
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= s_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wp_q <= wp_q + AW'(1);
      if (pop)  rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dpc_fifo

// ------------------------------------------------------------------
// Top
// ------------------------------------------------------------------
module dpc_top (
  input  wire logic               sys_clk,      // Core audio clock
  input  wire logic               rst_n,        // Sync reset, low
  input  wire logic               clk_en,       // Freezes state when low, except out_valid clears
  input  wire logic [7:0]         reg_addr,     // Register address
  input  wire logic [15:0]        reg_wdata,    // Write data
  input  wire logic               reg_wr,       // Write strobe
  input  wire logic               reg_rd,       // Read strobe
  output logic [15:0]             reg_rdata,    // Read data, next cycle
  input  wire logic               in_valid,     // Sample offered
  input  wire dpc_pkg::dpc_sample_s in_sample,  // Stereo sample in
  output logic                    in_ready,     // FIFO has room
  input  wire logic               master_mode,  // Interface is master
  input  wire logic               bit_clk_tick, // One bit clock period
  output logic                    out_valid,    // Sample pulse
  output dpc_pkg::dpc_sample_s    out_sample,   // Stereo sample out
  output dpc_pkg::dpc_cfg_s       cfg,          // Static settings
  output logic                    frame_clk_o,  // Frame clock drive
  output logic                    frame_clk_oe  // Frame clock enable
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        mono_q;
  logic        rate_mode_q;
  logic [1:0]  deemphasis_select_q;
  logic        fast_mod_q;
  logic [1:0]  inv_q;          // [1] left, [0] right
  logic [1:0]  ch_en_q;        // [1] left, [0] right
  logic [7:0]  vol_pend_q [2]; // Index 1 left, 0 right
  logic [7:0]  vol_app_q  [2];
  logic        fclk_en_q;
  logic [10:0] bcps_q;
  logic        clk_pol_q;
  logic [2:0]  div_q;
  logic        mute_q;
  logic        ramp_sel_q;
  logic [1:0]  ramping;
  logic [2:0]  fifo_level;
  logic        wr_vl;
  logic        wr_vr;
  logic        vu_hit;

  assign wr_vl  = reg_wr && (reg_addr == `DPC_OFS_VOL_L);
  assign wr_vr  = reg_wr && (reg_addr == `DPC_OFS_VOL_R);
  // R6 either update bit
  assign vu_hit = (wr_vl || wr_vr) && reg_wdata[`DPC_BIT_VU];

  // Control register writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mono_q      <= 1'b0;
      rate_mode_q <= 1'b0;
      deemphasis_select_q     <= 2'h0;
      fast_mod_q  <= 1'b0;
      inv_q       <= 2'h0;
      fclk_en_q   <= 1'b0;
      bcps_q      <= `DPC_RST_BCPS;
      clk_pol_q   <= 1'b0;
      div_q       <= 3'h0;
      // R12 muted at reset
      mute_q      <= `DPC_RST_MUTE;
      ramp_sel_q  <= 1'b0;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        `DPC_OFS_CTRL: begin
          mono_q      <= reg_wdata[`DPC_BIT_MONO];
          rate_mode_q <= reg_wdata[`DPC_BIT_RATE_MODE];
          deemphasis_select_q     <= reg_wdata[`DPC_BIT_DEEMPHASIS_SELECT_HI:`DPC_BIT_DEEMPHASIS_SELECT_LO];
          fast_mod_q  <= reg_wdata[`DPC_BIT_FAST_MOD];
          inv_q       <= {reg_wdata[`DPC_BIT_INV_L],
                          reg_wdata[`DPC_BIT_INV_R]};
        end
        `DPC_OFS_FRAME: begin
          fclk_en_q <= reg_wdata[`DPC_BIT_FCLK_EN];
          bcps_q    <= reg_wdata[10:0];
        end
        `DPC_OFS_CLK: begin
          clk_pol_q <= reg_wdata[`DPC_BIT_CLK_POL];
          div_q     <= reg_wdata[2:0];
        end
        `DPC_OFS_MUTE:      mute_q     <= reg_wdata[`DPC_BIT_MUTE];
        `DPC_OFS_MUTE_MODE: ramp_sel_q <= reg_wdata[`DPC_BIT_RAMP_SEL];
        default: ;
      endcase
    end
  end

  // Channel enables and volumes, one slice per channel
  for (genvar c = 0; c < 2; c++) begin : g_vol_reg
    logic wr_me;
    assign wr_me = (c == 1) ? wr_vl : wr_vr;
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        // R13 disabled at reset
        ch_en_q[c]    <= 1'b0;
        // R8 reset to 0dB
        vol_pend_q[c] <= `DPC_RST_VOL;
        vol_app_q[c]  <= `DPC_RST_VOL;
      end else if (clk_en) begin
        if (wr_me) begin
          ch_en_q[c]    <= reg_wdata[`DPC_BIT_CH_EN];
          vol_pend_q[c] <= reg_wdata[7:0];
        end
        // R6 both channels update together
        if (vu_hit) begin
          vol_app_q[c] <= wr_me ? reg_wdata[7:0] : vol_pend_q[c];
        end
      end
    end
  end

  // Read data, one cycle after the strobe; update bit reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          `DPC_OFS_CTRL:
            reg_rdata <= {2'h0, mono_q, rate_mode_q, 6'h00, deemphasis_select_q,
                          fast_mod_q, 1'b0, inv_q};
          `DPC_OFS_VOL_L: reg_rdata <= {ch_en_q[1], 7'h00, vol_pend_q[1]};
          `DPC_OFS_VOL_R: reg_rdata <= {ch_en_q[0], 7'h00, vol_pend_q[0]};
          `DPC_OFS_FRAME: reg_rdata <= {4'h0, fclk_en_q, bcps_q};
          `DPC_OFS_CLK:   reg_rdata <= {11'h000, clk_pol_q, 1'b0, div_q};
          `DPC_OFS_MUTE:  reg_rdata <= {1'b0, mute_q, 14'h0000};
          `DPC_OFS_MUTE_MODE: reg_rdata <= {1'b0, ramp_sel_q, 14'h0000};
          `DPC_OFS_STATUS:
            reg_rdata <= {8'h00, frame_clk_o, fifo_level, 2'h0, ramping};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample-rate tick
  // ----------------------------------------------------------------
  logic [11:0] cps;
  logic [3:0]  halves;
  logic [14:0] period;
  logic [14:0] div_cnt_q;
  logic        sample_tick;

  // R2 clocks per sample
  assign cps = rate_mode_q ? `DPC_CPS_USB : `DPC_CPS_NORMAL;

  // R11 divider in half steps; reserved code acts as divide by one
  always_comb begin
    unique case (div_q)
      3'h0: halves = 4'h2;
      3'h1: halves = 4'h3;
      3'h2: halves = 4'h4;
      3'h3: halves = 4'h6;
      3'h4: halves = 4'h8;
      3'h5: halves = 4'hb;
      3'h6: halves = 4'hc;
      default: halves = 4'h2;
    endcase
  end
  assign period      = 15'((cps * halves) >> 1);
  assign sample_tick = (div_cnt_q >= period - 15'h0001);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt_q <= 15'h0000;
    end else if (clk_en) begin
      div_cnt_q <= sample_tick ? 15'h0000 : div_cnt_q + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // FIFO: drained one word per sample tick
  // ----------------------------------------------------------------
  dpc_sample_s fifo_out;
  logic        fifo_valid;
  logic        take;

  assign take = sample_tick & fifo_valid;

  dpc_fifo #(
    .WIDTH ($bits(dpc_sample_s)),
    .DEPTH (`DPC_FIFO_DEPTH)
  ) u_fifo (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .ce      (clk_en),
    .s_valid (in_valid),
    .s_ready (in_ready),
    .s_data  (in_sample),
    .m_valid (fifo_valid),
    .m_ready (sample_tick),
    .m_data  (fifo_out),
    .level   (fifo_level)
  );

  // ----------------------------------------------------------------
  // Gain path
  // ----------------------------------------------------------------
  // Fractional 2^(k/16) in Q1.15
  function automatic logic [15:0] mant(input logic [3:0] k);
    unique case (k)
      4'h0: mant = 16'h8000;  4'h1: mant = 16'h85ab;
      4'h2: mant = 16'h8b96;  4'h3: mant = 16'h91c4;
      4'h4: mant = 16'h9838;  4'h5: mant = 16'h9ef5;
      4'h6: mant = 16'ha5ff;  4'h7: mant = 16'had58;
      4'h8: mant = 16'hb505;  4'h9: mant = 16'hbd09;
      4'ha: mant = 16'hc567;  4'hb: mant = 16'hce25;
      4'hc: mant = 16'hd745;  4'hd: mant = 16'he0cd;
      4'he: mant = 16'heac1;  default: mant = 16'hf525;
    endcase
  endfunction : mant

  logic       mute_d1_q;
  dpc_pcm_t   pre [2];
  logic [7:0] cur_q [2];
  logic       ramp_q [2];
  dpc_pcm_t   gained [2];
  logic signed [16:0] mono_sum;

  // R5 polarity; R1 mono sum of uninverted samples, halved, overrides it
  assign mono_sum = 17'(fifo_out.left) + 17'(fifo_out.right);
  always_comb begin
    pre[1] = inv_q[1] ? dpc_pcm_t'(-fifo_out.left)  : fifo_out.left;
    pre[0] = inv_q[0] ? dpc_pcm_t'(-fifo_out.right) : fifo_out.right;
    if (mono_q) begin
      pre[1] = dpc_pcm_t'(mono_sum >>> 1);
      pre[0] = dpc_pcm_t'(mono_sum >>> 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) mute_d1_q <= `DPC_RST_MUTE;
    else if (clk_en) mute_d1_q <= mute_q;
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [8:0]  e;
    logic signed [4:0]  sh;
    logic signed [32:0] prod;
    logic signed [32:0] scaled;
    logic [5:0]         rsh;

    // R7 0.375dB per code around 0dB at code 0xc0
    assign e      = $signed({1'b0, cur_q[c]}) - $signed(`DPC_VOL_0DB);
    assign sh     = 5'(e >>> 4);
    assign rsh    = 6'(5'sd15 - sh);
    assign prod   = pre[c] * $signed({1'b0, mant(e[3:0])});
    assign scaled = prod >>> rsh;

    // R7 code zero mutes; saturate
    always_comb begin
      if (cur_q[c] == 8'h00) begin
        gained[c] = 16'sh0000;
      end else if (scaled > 33'sh7fff) begin
        gained[c] = 16'sh7fff;
      end else if (scaled < -33'sh8000) begin
        gained[c] = -16'sh8000;
      end else begin
        gained[c] = dpc_pcm_t'(scaled);
      end
    end

    // R14 jump or ramp on unmute
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        cur_q[c]  <= 8'h00;
        ramp_q[c] <= 1'b0;
      end else if (clk_en) begin
        if (mute_q) begin
          cur_q[c]  <= 8'h00;
          ramp_q[c] <= 1'b0;
        end else if (mute_d1_q && ramp_sel_q) begin
          ramp_q[c] <= 1'b1;
        end else if (ramp_q[c]) begin
          if (cur_q[c] >= vol_app_q[c]) begin
            cur_q[c]  <= vol_app_q[c];
            ramp_q[c] <= 1'b0;
          end else if (sample_tick) begin
            cur_q[c] <= cur_q[c] + 8'h01;
          end
        end else begin
          cur_q[c] <= vol_app_q[c];
        end
      end
    end
    assign ramping[c] = ramp_q[c];
  end

  // R13 disabled channel outputs zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      out_sample <= '0;
    end else if (clk_en) begin
      out_valid <= take;
      if (take) begin
        out_sample.left  <= ch_en_q[1] ? gained[1] : 16'sh0000;
        out_sample.right <= ch_en_q[0] ? gained[0] : 16'sh0000;
      end
    end else begin
      out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Settings out; R3 and R4 pass to the filter and modulator
  // ----------------------------------------------------------------
  assign cfg.frame_rate_mode_select = rate_mode_q;
  assign cfg.deemphasis_select      = deemphasis_select_q;
  assign cfg.modulator_fast_clock   = fast_mod_q;
  assign cfg.playback_clock_invert  = clk_pol_q;
  assign cfg.sample_rate_divider    = div_q;
  assign cfg.left_channel_enable    = ch_en_q[1];
  assign cfg.right_channel_enable   = ch_en_q[0];

  // ----------------------------------------------------------------
  // Frame clock generator
  // ----------------------------------------------------------------
  logic [10:0] bc_cnt_q;
  logic [10:0] bc_lim;
  logic        fclk_q;
  logic        fclk_run;

  // R9 master mode and enable
  assign fclk_run = fclk_en_q & master_mode;
  // R10 codes below eight treated as eight
  assign bc_lim   = (bcps_q < `DPC_MIN_BCPS) ? `DPC_MIN_BCPS : bcps_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bc_cnt_q <= 11'h000;
      fclk_q   <= 1'b0;
    end else if (clk_en) begin
      if (!fclk_run) begin
        bc_cnt_q <= 11'h000;
        fclk_q   <= 1'b0;
      end else if (bit_clk_tick) begin
        if (bc_cnt_q >= bc_lim - 11'h001) begin
          bc_cnt_q <= 11'h000;
          fclk_q   <= ~fclk_q;
        end else begin
          bc_cnt_q <= bc_cnt_q + 11'h001;
        end
      end
    end
  end

  assign frame_clk_o  = fclk_q ^ clk_pol_q;
  assign frame_clk_oe = fclk_run;

endmodule : dpc_top

// ===== dpc_top_chk.sv
// Port-level checks for the playback control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module dpc_top_chk (
  input wire logic                 sys_clk,      // Clock
  input wire logic                 rst_n,        // Reset, low
  input wire logic                 clk_en,       // Run enable
  input wire logic [7:0]           reg_addr,     // Address
  input wire logic                 reg_wr,       // Write strobe
  input wire logic                 reg_rd,       // Read strobe
  input wire logic [15:0]          reg_rdata,    // Read data
  input wire logic                 master_mode,  // Master
  input wire logic                 bit_clk_tick, // Bit tick
  input wire logic                 out_valid,    // Sample pulse
  input wire dpc_pkg::dpc_sample_s out_sample,   // Sample out
  input wire dpc_pkg::dpc_cfg_s    cfg,          // Settings
  input wire logic                 frame_clk_o,  // Frame clock
  input wire logic                 frame_clk_oe  // Frame enable
);
  import dpc_pkg::*;
  logic [11:0] gap_q;
  logic        seen_q;

  // Cycles since the last sample pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gap_q  <= 12'h000;
      seen_q <= 1'b0;
    end else if (clk_en && out_valid) begin
      gap_q  <= 12'h000;
      seen_q <= 1'b1;
    end else if (clk_en && gap_q != 12'hfff) begin
      gap_q <= gap_q + 12'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (
    !reg_rd && clk_en |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  unmapped_rd_a: assert property (
    reg_rd && clk_en && reg_addr == 8'h31 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cfg_reset_a: assert property ($rose(rst_n) |-> cfg == '0)
    else $error("settings not cleared by reset");
  cfg_write_a: assert property (!$past(reg_wr) |-> $stable(cfg))
    else $error("settings changed without a write");
  oe_master_a: assert property (
    !master_mode && !$past(master_mode) |-> !frame_clk_oe)
    else $error("frame clock driven in slave mode");
  frame_hold_a: assert property (
    frame_clk_oe && $past(frame_clk_oe) && !$past(bit_clk_tick)
    && !$past(reg_wr) |-> $stable(frame_clk_o))
    else $error("frame clock moved without a bit tick");
  sample_gap_a: assert property (
    out_valid && seen_q |-> gap_q >= 12'h0ff)
    else $error("sample pulses closer than 256 clocks");
  pulse_one_a: assert property (out_valid |=> !out_valid)
    else $error("sample pulse longer than one cycle");
  left_off_a: assert property (
    out_valid && !$past(cfg.left_channel_enable)
    |-> out_sample.left == 16'h0)
    else $error("disabled left channel not silent");
  right_off_a: assert property (
    out_valid && !$past(cfg.right_channel_enable)
    |-> out_sample.right == 16'h0)
    else $error("disabled right channel not silent");
endmodule : dpc_top_chk

bind dpc_top dpc_top_chk dpc_top_chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .master_mode(master_mode),
  .bit_clk_tick(bit_clk_tick), .out_valid(out_valid),
  .out_sample(out_sample), .cfg(cfg), .frame_clk_o(frame_clk_o),
  .frame_clk_oe(frame_clk_oe));

// ===== tb.sv
// Self-checking bench for the playback control block.
// Assumes dpc_map.svh in the include path; clk_en dropped once.
`timescale 1ns/1ps
`include "dpc_map.svh"
module tb;
  import dpc_pkg::*;
  logic        sys_clk, rst_n, clk_en, reg_wr, reg_rd, in_valid;
  logic        master_mode, bit_clk_tick, tick_on, in_ready;
  logic        out_valid, frame_clk_o, frame_clk_oe;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  dpc_sample_s in_sample, out_sample, got;
  dpc_cfg_s    cfg;
  int          n_fail, samples_checked, gap;
  // Rate table: control word, clock word, clocks per sample
  localparam logic [15:0] RT [5][3] = '{'{16'h0, 16'h1, 16'd384},
    '{16'h0, 16'h5, 16'd1408}, '{16'h1000, 16'h0, 16'd272},
    '{16'h0, 16'h6, 16'd1536}, '{16'h1000, 16'h2, 16'd544}};

  dpc_top dpc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_sample(in_sample), .in_ready(in_ready),
    .master_mode(master_mode), .bit_clk_tick(bit_clk_tick),
    .out_valid(out_valid), .out_sample(out_sample), .cfg(cfg),
    .frame_clk_o(frame_clk_o), .frame_clk_oe(frame_clk_oe));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Bit tick every other cycle while running
  always @(posedge sys_clk) bit_clk_tick <= tick_on & ~bit_clk_tick;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdck(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask : rdck

  task automatic push(input logic [15:0] l, r);
    @(posedge sys_clk);
    in_valid  <= 1'b1;
    in_sample <= {l, r};
    @(posedge sys_clk);
    in_valid <= 1'b0;
  endtask : push

  task automatic wait_out;
    gap = 0;
    do begin
      @(posedge sys_clk);
      #1 gap++;
      if (gap > 3000) begin
        chk("wait_done", 16'h0, 16'h1);
        wrap_up();
      end
    end while (out_valid !== 1'b1);
    got = out_sample;
  endtask : wait_out

  task automatic play(input logic [15:0] l, r, el, er);
    push(l, r);
    wait_out();
    chk("out_left", got.left, el);
    chk("out_right", got.right, er);
  endtask : play

  task automatic t_reset;
    logic [7:0]  a [7] = '{8'h30, 8'h32, 8'h33, 8'h35, 8'h36, 8'h3a, 8'h31};
    logic [15:0] e [7] = '{16'h0, 16'hc0, 16'hc0, 16'h40, 16'h0,
                           16'h4000, 16'h0};
    for (int i = 0; i < 7; i++) rdck(a[i], e[i]);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 16'h3008 | 16'(i << 4);
      wr(`DPC_OFS_CTRL, d);
      #1 chk("deemph", 16'(cfg.deemphasis_select), 16'(i));
      chk("rate_fast", {cfg.frame_rate_mode_select,
        cfg.modulator_fast_clock}, 16'h3);
      rdck(`DPC_OFS_CTRL, d);
    end
    for (int i = 0; i < 7; i++) begin
      wr(`DPC_OFS_CLK, 16'h0010 | 16'(i));
      #1 chk("clk_ctrl", {cfg.playback_clock_invert,
        cfg.sample_rate_divider}, 16'(8 + i));
    end
    wr(8'h31, 16'hffff);
    rdck(8'h31, 16'h0);
    wr(`DPC_OFS_CTRL, 16'h0);
    wr(`DPC_OFS_CLK, 16'h0);
    clk_en <= 1'b0;
    wr(`DPC_OFS_CTRL, 16'h2000);
    clk_en <= 1'b1;
    rdck(`DPC_OFS_CTRL, 16'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_vol;
    wr(`DPC_OFS_VOL_L, 16'h80c0);
    wr(`DPC_OFS_VOL_R, 16'h80c0);
    wr(`DPC_OFS_MUTE, 16'h0);
    play(16'h03e8, 16'hfe70, 16'h03e8, 16'hfe70);
    wr(`DPC_OFS_VOL_L, 16'h80b0);
    play(16'h03e8, 16'hfe70, 16'h03e8, 16'hfe70);
    wr(`DPC_OFS_VOL_R, 16'h81c0);
    play(16'h03e8, 16'hfe70, 16'h01f4, 16'hfe70);
    wr(`DPC_OFS_CTRL, 16'h0002);
    play(16'h03e8, 16'hfe70, 16'hfe0c, 16'hfe70);
    wr(`DPC_OFS_CTRL, 16'h2000);
    play(16'h03e8, 16'hfe70, 16'h0096, 16'h012c);
    wr(`DPC_OFS_CTRL, 16'h0);
    wr(`DPC_OFS_VOL_R, 16'h80d0);
    wr(`DPC_OFS_VOL_L, 16'h8100);
    play(16'h03e8, 16'hfe70, 16'h0000, 16'hfce0);
    wr(`DPC_OFS_VOL_L, 16'h81c0);
    wr(`DPC_OFS_VOL_R, 16'h00d0);
    play(16'h03e8, 16'hfe70, 16'h03e8, 16'h0000);
    wr(`DPC_OFS_MUTE, 16'h4000);
    play(16'h03e8, 16'hfe70, 16'h0000, 16'h0000);
    $display("t_vol done");
  endtask : t_vol

  task automatic t_fifo;
    wr(`DPC_OFS_MUTE, 16'h0);
    push(16'h0, 16'h0);
    wait_out();
    for (int k = 1; k < 5; k++) push(16'(k), 16'h7);
    #1 chk("in_ready_full", in_ready, 16'h0);
    for (int k = 1; k < 5; k++) begin
      wait_out();
      chk("fifo_order", got.left, 16'(k));
      chk("right_off", got.right, 16'h0);
      if (k > 1) chk("period", gap[15:0], 16'd256);
    end
    chk("in_ready_empty", in_ready, 16'h1);
    $display("t_fifo done");
  endtask : t_fifo

  // sample period per mode and divider
  task automatic t_rate;
    wr(`DPC_OFS_VOL_L, 16'h00c0);
    for (int i = 0; i < 5; i++) begin
      wr(`DPC_OFS_CTRL, RT[i][0]);
      wr(`DPC_OFS_CLK, RT[i][1]);
      repeat (3) push(16'h1, 16'h0);
      wait_out();
      wait_out();
      chk("period", gap[15:0], RT[i][2]);
      wait_out();
      chk("period", gap[15:0], RT[i][2]);
    end
    wr(`DPC_OFS_CTRL, 16'h0);
    wr(`DPC_OFS_CLK, 16'h0);
    wr(`DPC_OFS_VOL_L, 16'h80c0);
    $display("t_rate done");
  endtask : t_rate

  task automatic t_ramp;
    wr(`DPC_OFS_MUTE, 16'h4000);
    wr(`DPC_OFS_MUTE_MODE, 16'h4000);
    wr(`DPC_OFS_MUTE, 16'h0);
    play(16'h03e8, 16'h0, 16'h0, 16'h0);
    rdck(`DPC_OFS_STATUS, 16'h0003);
    rdck(`DPC_OFS_MUTE_MODE, 16'h4000);
    $display("t_ramp done");
  endtask : t_ramp

  task automatic frame_per(input logic [15:0] e);
    logic v;
    int   n;
    #1 v = frame_clk_o;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        #1 n++;
        if (n > 200) begin
          chk("frame_wait", 16'h0, 16'h1);
          wrap_up();
        end
      end while (frame_clk_o === v);
      v = frame_clk_o;
    end
    chk("frame_phase", n[15:0], e);
  endtask : frame_per

  task automatic t_frame;
    @(posedge sys_clk);
    master_mode <= 1'b1;
    tick_on     <= 1'b1;
    wr(`DPC_OFS_FRAME, 16'h0808);
    frame_per(16'd16);
    wr(`DPC_OFS_FRAME, 16'h0809);
    frame_per(16'd18);
    chk("frame_oe_on", frame_clk_oe, 16'h1);
    @(posedge sys_clk);
    master_mode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("frame_oe_off", frame_clk_oe, 16'h0);
    $display("t_frame done");
  endtask : t_frame

  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, in_valid, master_mode} = '0;
    {tick_on, reg_addr, reg_wdata} = '0;
    in_sample = '0;
    clk_en = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_vol();
    t_fifo();
    t_rate();
    t_ramp();
    t_frame();
    wrap_up();
  end
endmodule : tb
